/* File: testbench/tb_watchdog_timeout_response.sv */
// Purpose: self-checking bench for the watchdog timeout block
// Assumes: crystal tick every core clock (XTAL_DIV_P = 1)
// Notes:   each scenario starts from a hardware reset
`timescale 1ns/10ps
module tb_watchdog_timeout_response;
  import wdt_pkg::*;
  logic       clk_in;
  logic       resetn_in;
  logic       ce_in;
  logic       wr_en_in;
  logic       instr_in;
  logic [7:0] wr_data_in;
  logic [7:0] rd_data_out;
  logic       sys_reset_out;
  logic       wd_irq_out;
  logic       wd_irq_high_prio_out;
  int         num_errors;
  int         comparisons;
  int         cycles;

  watchdog_timeout_response #(.XTAL_DIV_P(1)) u_watchdog_timeout_response (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .wr_en_in(wr_en_in),
    .instr_in(instr_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
    .sys_reset_out(sys_reset_out), .wd_irq_out(wd_irq_out),
    .wd_irq_high_prio_out(wd_irq_high_prio_out));

  // ****************************************************
  // clock, hang guard and shared tasks
  // ****************************************************
  initial begin
    clk_in = 0;
    forever #20 clk_in = ~clk_in;
  end

  // hang guard well above the longest scenario
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      $display("Error at %0t: %s", $time, msg);
      num_errors++;
    end
  endtask

  task automatic do_reset();
    @(posedge clk_in);
    #1 resetn_in = 0;
    repeat (6) @(posedge clk_in);
    #1 resetn_in = 1;
  endtask

  // optional unlock instruction, then the real control write
  task automatic wr(input logic [7:0] d, input bit armed);
    if (armed) begin
      @(posedge clk_in);
      #1 wr_en_in = 1;
      instr_in = 1;
      wr_data_in = 8'h01;
    end
    @(posedge clk_in);
    #1 wr_en_in = 1;
    instr_in = 1;
    wr_data_in = d;
    @(posedge clk_in);
    #1 wr_en_in = 0;
    instr_in = 0;
  endtask

  // waits for the expiry pulse and judges its moment, kind and width
  task automatic expect_expiry(input bit irq, input int exp);
    int n;
    n = 0;
    // align to a falling edge first, so a pulse already up is judged whole
    @(negedge clk_in);
    while (n < exp + 8 && sys_reset_out !== 1'b1 && wd_irq_out !== 1'b1) begin
      @(negedge clk_in);
      n++;
    end
    check(n > exp - 8 && n < exp + 8, "expiry moment");
    check(wd_irq_out === irq && sys_reset_out === !irq, "response kind");
    @(negedge clk_in);
    check(wd_irq_out === 1'b0 && sys_reset_out === 1'b0, "pulse width");
  endtask

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic reset_values();
    do_reset();
    @(negedge clk_in);
    check(rd_data_out === CTRL_RESET, "reset value");
    check(wd_irq_high_prio_out === 1'b1, "fixed priority");
  endtask

  task automatic irq_interval();
    do_reset();
    wr(8'h0A, 1);
    expect_expiry(1, 512);
    repeat (3) @(negedge clk_in);
    check(rd_data_out[FLAG_BIT] === 1'b1, "flag after irq");
    wr(8'h08, 1);
    repeat (3) @(negedge clk_in);
    check(rd_data_out[FLAG_BIT] === 1'b0, "flag not cleared");
  endtask

  task automatic reset_response();
    do_reset();
    wr(8'h12, 1);
    expect_expiry(0, 1024);
    repeat (3) @(negedge clk_in);
    check(rd_data_out[FLAG_BIT] === 1'b1, "flag after reset");
  endtask

  task automatic refresh_keeps_alive();
    do_reset();
    wr(8'h02, 1);
    repeat (3) begin
      repeat (400) @(negedge clk_in);
      check(sys_reset_out === 1'b0, "refreshed yet expired");
      check(rd_data_out[FLAG_BIT] === 1'b0, "expiry while refreshed");
      wr(8'h02, 1);
    end
    expect_expiry(0, 512);
  endtask

  task automatic write_lock();
    do_reset();
    wr(8'h30, 0);
    repeat (3) @(negedge clk_in);
    check(rd_data_out[7:4] === 4'h1, "bare write landed");
    wr(8'h01, 0);
    @(posedge clk_in);
    #1 instr_in = 1;
    @(posedge clk_in);
    #1 instr_in = 0;
    wr(8'h30, 0);
    repeat (3) @(negedge clk_in);
    check(rd_data_out[7:4] === 4'h1, "late write landed");
    wr(8'h30, 1);
    repeat (3) @(negedge clk_in);
    check(rd_data_out[7:4] === 4'h3, "armed write lost");
  endtask

  task automatic immediate_code();
    int seen;
    seen = 0;
    do_reset();
    wr(8'h88, 1);
    expect_expiry(0, 0);
    wr(8'h92, 1); // reserved code, refresh leaves hold
    repeat (600) begin
      @(negedge clk_in);
      if (sys_reset_out !== 1'b0 || wd_irq_out !== 1'b0) seen++;
    end
    check(seen == 0, "reserved code expired");
  endtask

  // counting pauses while the clock enable is low
  task automatic clock_enable_freeze();
    do_reset();
    wr(8'h0A, 1);
    repeat (200) @(posedge clk_in);
    #1 ce_in = 0;
    repeat (300) @(posedge clk_in);
    #1 ce_in = 1;
    expect_expiry(1, 313);
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    resetn_in = 0;
    ce_in = 1;
    wr_en_in = 0;
    instr_in = 0;
    wr_data_in = 8'h00;
    num_errors = 0;
    comparisons = 0;
    cycles = 0;
    reset_values();
    irq_interval();
    reset_response();
    refresh_keeps_alive();
    write_lock();
    immediate_code();
    clock_enable_freeze();
    test_done();
  end
endmodule

/* File: verilog/tick_divider.sv */
// Purpose: makes a one-cycle crystal-rate tick from the core clock
// Assumes: period is at least one cycle
// Notes:   restarts when clr_in is high
`timescale 1ns/10ps
module tick_divider #(
  parameter int DIV = 763
) (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic ce_in,
  input  wire logic clr_in,
  output logic      tick_out
);
  logic [15:0] cnt_ff;

  // ****************************************************************
  // divider counter
  // ****************************************************************
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_ff   <= 16'h0000;
      tick_out <= 1'b0;
    end else if (ce_in) begin
      if (clr_in || cnt_ff == 16'(DIV - 1)) begin
        cnt_ff <= 16'h0000;
      end else begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
      tick_out <= !clr_in && (cnt_ff == 16'(DIV - 1));
    end
  end
endmodule

/* File: verilog/watchdog_timeout_response.sv */
// Purpose: watchdog with selectable reset or interrupt response
// Assumes: software writes the control register as an 8-bit sfr port
// Notes:   a write lands only right after one that set the unlock bit
// Behaviour
// - codes 4..7 give 250..2000 ms, code 8 resets at once, above reserved
// - response bit set gives an interrupt on expiry, not a reset, for codes below 8
// - response bit clear gives a system reset on expiry without refresh
// - the interrupt ignores the global interrupt disable
// - the interrupt is always high priority, never configurable
// - with interrupt response the block works as an interval timer
// - period equals two to the select value times 512 crystal periods
// - a control write counts only right after the unlock-setting write
`timescale 1ns/10ps
module watchdog_timeout_response
  import wdt_pkg::*;
#(
  parameter int XTAL_DIV_P = wdt_pkg::XTAL_DIV
) (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       ce_in,
  input  wire logic       wr_en_in,
  input  wire logic       instr_in,
  input  wire logic [7:0] wr_data_in,
  output logic      [7:0] rd_data_out,
  output logic            sys_reset_out,
  output logic            wd_irq_out,
  output logic            wd_irq_high_prio_out
);
  import wdt_pkg::*;

  logic [3:0]      sel_ff;
  logic            irq_sel_ff;
  logic            flag_ff;
  logic            refresh_ff;
  logic            unlock_ff;
  logic            armed_ff;
  logic [CNT_W-1:0] cnt_ff;
  wd_state_e       state_ff;
  logic            xtal_tick;
  logic            wr_ok;
  logic            expire;
  logic [CNT_W-1:0] limit;

  // ****************************************************************
  // write unlock
  // ****************************************************************
  // a write is honoured only if the previous instruction set unlock
  assign wr_ok = wr_en_in && armed_ff;

  // armed for exactly the next instruction after an unlock write
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      armed_ff <= 1'b0;
    end else if (ce_in && instr_in) begin
      armed_ff <= wr_en_in && wr_data_in[UNLOCK_BIT] && !armed_ff;
    end
  end

  // ****************************************************************
  // timing
  // ****************************************************************
  // crystal tick source, restarted by refresh so a period starts on a whole tick
  tick_divider #(
    .DIV (XTAL_DIV_P)
  ) u_div (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .ce_in     (ce_in),
    .clr_in    (refresh_ff),
    .tick_out  (xtal_tick)
  );

  // crystal ticks to expiry: 2^sel * 512
  // codes above the immediate one never match, so they stay quiet
  assign limit  = CNT_W'(BASE_XTAL_TICKS) << sel_ff;
  assign expire = refresh_ff == 1'b0 && state_ff == WD_RUN &&
                  ((sel_ff == SEL_IMMEDIATE) ||
                   (sel_ff < SEL_IMMEDIATE && xtal_tick && cnt_ff >= limit - 1'b1));

  // tick counter, restarted by refresh
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_ff <= '0;
    end else if (ce_in) begin
      if (refresh_ff || expire) begin
        cnt_ff <= '0;
      end else if (xtal_tick) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sel_ff     <= CTRL_RESET[SEL_MSB_BIT:SEL_LSB_BIT];
      irq_sel_ff <= CTRL_RESET[IRQ_SEL_BIT];
      refresh_ff <= CTRL_RESET[REFRESH_BIT];
      unlock_ff  <= CTRL_RESET[UNLOCK_BIT];
    end else if (ce_in) begin
      if (wr_ok) begin
        sel_ff     <= wr_data_in[SEL_MSB_BIT:SEL_LSB_BIT];
        irq_sel_ff <= wr_data_in[IRQ_SEL_BIT];
        refresh_ff <= wr_data_in[REFRESH_BIT];
        unlock_ff  <= 1'b0;
      end else begin
        refresh_ff <= 1'b0; // refresh is a one-shot restart
        if (wr_en_in) begin
          unlock_ff <= wr_data_in[UNLOCK_BIT];
        end
      end
    end
  end

  // timeout flag, set wins over a software clear
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flag_ff <= CTRL_RESET[FLAG_BIT];
    end else if (ce_in) begin
      if (expire) begin
        flag_ff <= 1'b1;
      end else if (wr_ok && !wr_data_in[FLAG_BIT]) begin
        flag_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // response
  // ****************************************************************
  // hold parks the immediate code until a refresh, so it resets only once
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff             <= WD_RUN;
      sys_reset_out        <= 1'b0;
      wd_irq_out           <= 1'b0;
      wd_irq_high_prio_out <= 1'b1;
    end else if (ce_in) begin
      wd_irq_high_prio_out <= 1'b1; // fixed priority
      wd_irq_out           <= 1'b0;
      sys_reset_out        <= 1'b0;
      unique case (state_ff)
        WD_RUN: begin
          if (expire) begin
            state_ff <= WD_EXPIRE;
            if (irq_sel_ff && sel_ff != SEL_IMMEDIATE) begin
              wd_irq_out <= 1'b1; // no mask input exists
            end else begin
              sys_reset_out <= 1'b1;
            end
          end
        end
        WD_EXPIRE: begin
          state_ff <= WD_HOLD;
        end
        WD_HOLD: begin
          if (refresh_ff || !(sel_ff == SEL_IMMEDIATE)) begin
            state_ff <= WD_RUN;
          end
        end
        default: begin
          state_ff <= WD_RUN;
        end
      endcase
    end
  end

  // readback of the whole register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_out <= CTRL_RESET;
    end else if (ce_in) begin
      rd_data_out <= {sel_ff, irq_sel_ff, flag_ff, refresh_ff, unlock_ff};
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_flag_on_exp: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && expire |=> flag_ff) else $error("flag not set on expiry");
  chk_irq_no_rst: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wd_irq_out |-> !sys_reset_out) else $error("irq and reset together");
  chk_rst_resp: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && expire && !irq_sel_ff |=> sys_reset_out) else $error("no reset");
  chk_prio_fixed: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ##1 wd_irq_high_prio_out) else $error("priority dropped");
  chk_unlock_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && wr_en_in && !armed_ff && !expire |=> $stable(sel_ff))
    else $error("locked write landed");
  chk_imm_reset: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && state_ff == WD_RUN && sel_ff == SEL_IMMEDIATE && !refresh_ff
    |=> sys_reset_out) else $error("immediate code did not reset");
  chk_irq_resp: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && expire && irq_sel_ff && sel_ff != SEL_IMMEDIATE |=> wd_irq_out)
    else $error("no interrupt on expiry");
  chk_refresh_clr: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && refresh_ff |=> cnt_ff == '0) else $error("refresh kept count");

  // each response pulse lasts one enabled cycle
  chk_rst_single: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && sys_reset_out |=> !sys_reset_out)
    else $error("reset pulse too long");
  chk_irq_single: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && wd_irq_out |=> !wd_irq_out)
    else $error("interrupt pulse too long");

  // nothing fires before the period ends, or ever on a reserved code
  chk_no_early: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && state_ff == WD_RUN && sel_ff < SEL_IMMEDIATE && cnt_ff < limit - 1'b1
    |=> !sys_reset_out && !wd_irq_out) else $error("expired early");
  chk_reserved_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && state_ff == WD_RUN && sel_ff > SEL_IMMEDIATE
    |=> !sys_reset_out && !wd_irq_out) else $error("reserved code expired");

  // the timeout flag stays until software clears it
  chk_flag_sticky: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && flag_ff && !wr_ok |=> flag_ff) else $error("flag lost");
endmodule

/* File: verilog/wdt_pkg.sv */
// Purpose: shared constants for the watchdog timeout and response block
// Assumes: 8-bit control register reached as a special function register
// Notes:   bit positions, reset values and timing counts live here; tick_divider keeps its own default DIV of 763
package wdt_pkg;

  // ****************************************************************
  // control register layout
  // ****************************************************************
  localparam int          SEL_MSB_BIT     = 7;
  localparam int          SEL_LSB_BIT     = 4;
  localparam int          IRQ_SEL_BIT     = 3;
  localparam int          FLAG_BIT        = 2;
  localparam int          REFRESH_BIT     = 1;
  localparam int          UNLOCK_BIT      = 0;
  localparam logic [7:0]  CTRL_RESET      = 8'h10;
  localparam logic [3:0]  SEL_IMMEDIATE   = 4'h8;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          XTAL_HZ         = 32768;
  localparam int          CLK_HZ          = 25000000;
  localparam int          BASE_XTAL_TICKS = 512;
  // crystal tick as a count of core clocks, rounded down, at least one
  localparam int          XTAL_DIV        = CLK_HZ / XTAL_HZ;
  localparam int          CNT_W           = 20;

  typedef enum logic [1:0] {
    WD_RUN    = 2'b00,
    WD_EXPIRE = 2'b01,
    WD_HOLD   = 2'b10
  } wd_state_e;

endpackage
